//--- src/ssil_regs.svh
// Register offsets, field positions, reset values and timing figures
// for the servo sequence-input block. Assumes a byte-addressed,
// word-aligned register port with 8 address bits.
`ifndef SSIL_REGS_SVH
`define SSIL_REGS_SVH

// ----
// Register byte offsets
// ----
`define SSIL_A_CTRL     8'h00
`define SSIL_A_GAIN     8'h04
`define SSIL_A_GNUM1    8'h08
`define SSIL_A_GNUM2    8'h0C
`define SSIL_A_GNUM3    8'h10
`define SSIL_A_GNUM4    8'h14
`define SSIL_A_GDEN     8'h18
`define SSIL_A_STAT     8'h1C
`define SSIL_A_PCNT     8'h20
`define SSIL_A_ASG_HI   2'h1
`define SSIL_N_FN       12

// ----
// Field positions
// ----
`define SSIL_F_OTEN     1:0
`define SSIL_F_OTSTOP   3:2
`define SSIL_F_ECLEDGE  4
`define SSIL_F_LMODE    8:5
`define SSIL_F_IPGDIS   9
`define SSIL_F_GPOS     3:0
`define SSIL_F_GSPD     7:4
`define SSIL_F_GTRQ     11:8
`define SSIL_F_DFILT    13:12
`define SSIL_F_TERM     3:0
`define SSIL_F_INV      4

// ----
// Function slots of the input assignment table
// ----
`define SSIL_FN_FOT     0
`define SSIL_FN_ROT     1
`define SSIL_FN_ACLR    2
`define SSIL_FN_ECL     3
`define SSIL_FN_MSW     4
`define SSIL_FN_GAIN_SELECT_IN    5
`define SSIL_FN_DFA     6
`define SSIL_FN_DFB     7
`define SSIL_FN_GEA     8
`define SSIL_FN_GEB     9
`define SSIL_FN_IPG     10
`define SSIL_FN_SON     11
`define SSIL_FIX_POL    12'h00C

// ----
// Setting codes and reset values
// ----
`define SSIL_OT_STOP    2'h1
`define SSIL_OT_ALARM   2'h2
`define SSIL_LM_PS      4'h3
`define SSIL_LM_PT      4'h4
`define SSIL_LM_ST      4'h5
`define SSIL_LM_SPD     4'h1
`define SSIL_LM_TRQ     4'h2
`define SSIL_GSW_PIN    4'h2
`define SSIL_DF_PAIR    2'h1
`define SSIL_DF_ONE     2'h2
`define SSIL_TERM_MAX   4'hA
`define SSIL_TERM_ECL   4'h7
`define SSIL_TERM_IPG   4'hA
`define SSIL_RST_GEAR   1

// ----
// Alarm bits and the classes that a clear cannot release
// ----
`define SSIL_AL_OT      0
`define SSIL_AL_ECLASG  1
`define SSIL_AL_IPGASG  2
`define SSIL_AL_EXTRES  3
`define SSIL_AL_EXTKEEP 4
`define SSIL_ALM_KEEP   5'h16

// ----
// Timing
// ----
`define SSIL_CLK_HZ     40000000
`define SSIL_CLR_US     120000

`endif

//--- src/ssil_pkg.sv
// Types shared by the servo sequence-input block.
// Assumes ssil_regs.svh carries every number.
package ssil_pkg;

    // ----
    // Active control loop
    // ----
    typedef enum logic [1:0]
    {
        SSIL_LOOP_POS = 2'h0,
        SSIL_LOOP_SPD = 2'h1,
        SSIL_LOOP_TRQ = 2'h2
    } ssil_loop_e;

    // ----
    // Alarm-clear sequencer, one-hot
    // ----
    typedef enum logic [2:0]
    {
        SSIL_CLR_IDLE = 3'h1,
        SSIL_CLR_HOLD = 3'h2,
        SSIL_CLR_REL  = 3'h4
    } ssil_clr_e;

    // ----
    // Drive actions handed to the servo loops
    // ----
    typedef struct packed
    {
        logic       main_power_en;
        logic       ot_stop_fwd;
        logic       ot_stop_rev;
        logic [1:0] ot_stop_sel;
        logic       errcnt_zero;
        ssil_loop_e active_loop;
        logic       gain_set2;
        logic [3:0] filter_en;
        logic [4:0] alarm;
    } ssil_drive_s;

endpackage

//--- src/ssil_seq_input.sv
// Sequence-input decoder of a servo drive: ten general input
// terminals are mapped to drive functions and turned into actions.
// Assumes terminals come from outside the clock domain, command
// pulses and alarm events come from logic on ref_clk.
//
// Function
// - Overtravel inputs disabled after reset
// - Setting 1: overtravel picks configured stop
// - Setting 2: overtravel raises protection alarm
// - Alarm-clear input polarity fixed active-high
// - Rising edge starts clear; 120 ms releases
// - Completed alarm clear zeroes error counter
// - Latched alarm classes survive alarm clear
// - Error-counter clear only on terminal seven
// - Error-counter clear polarity fixed active-high
// - Error-counter clear zeroes position error
// - Clear on level or rising edge
// - Modes 3-5: switch input picks loop
// - Gain mode 2: input picks gain set
// - Filter select pairs or one of four
// - Two inputs choose one of four numerators
// - Pulse inhibit disabled at reset, enable 0
// - Pulse inhibit only on terminal ten
// - Inhibit ON drops and stops counting pulses
// - Other functions on any terminal, polarity unless fixed
// - Main power only while servo-on asserted
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "ssil_regs.svh"

module ssil_seq_input
#(
    parameter int GW           = 16,
    parameter int CLR_HOLD_CYC =
        `SSIL_CLR_US * (`SSIL_CLK_HZ / 1000000)
)
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output      logic [31:0]          reg_rdata,
    // General input terminals 1 to 10, bit 0 is terminal 1
    input  wire logic [9:0]           seq_terminal,
    // Command pulses and alarm events from the drive
    input  wire logic                 cmd_pulse_in,
    input  wire logic                 ext_alarm_res,
    input  wire logic                 ext_alarm_keep,
    // Drive actions
    output      ssil_pkg::ssil_drive_s drive,
    output      logic [GW-1:0]        gear_num,
    output      logic [GW-1:0]        gear_den,
    output      logic                 cmd_pulse_out
);

    localparam int NF = `SSIL_N_FN;
    localparam int CW = $clog2(CLR_HOLD_CYC + 1);
    localparam logic [NF-1:0] FIXP = `SSIL_FIX_POL; // Fixed polarity

    // ----
    // Whole state of the block
    // ----
    typedef struct packed
    {
        logic [9:0]             s1;        // Sync stage one
        logic [9:0]             s2;        // Sync stage two
        logic [9:0]             s3;        // Sync stage three
        logic [9:0]             lvl;       // Accepted levels
        logic [1:0]             ot_en;     // Overtravel enable
        logic [1:0]             ot_stop;   // Overtravel stop choice
        logic                   ecl_edge;  // Clear on edge
        logic [3:0]             lmode;     // Control mode
        logic                   ipg_dis;   // Pulse inhibit disabled
        logic [11:0]            gsw;       // Gain switch modes
        logic [1:0]             dfilt;     // Filter selection
        logic [NF-1:0][4:0]     asg;       // Terminal assignment
        logic [3:0][GW-1:0]     gnum;      // Gear numerators
        logic [GW-1:0]          gden;      // Gear denominator
        ssil_pkg::ssil_clr_e    clr;       // Alarm-clear state
        logic [CW-1:0]          clr_cnt;   // Clear hold counter
        logic                   aclr_prv;  // Previous clear level
        logic                   ecl_prv;   // Previous ecl level
        logic [31:0]            pcnt;      // Accepted pulse count
        logic [31:0]            rdata;     // Read data
        ssil_pkg::ssil_drive_s  drv;       // Drive actions
        logic [GW-1:0]          gear;      // Selected numerator
        logic                   pulse;     // Passed command pulse
    } ssil_state_s;

    ssil_state_s q;        // Registered state
    ssil_state_s next_q;   // Next state

    logic [NF-1:0] fn;     // Decoded function levels
    logic [10:0]   ext;    // Levels with terminal 0 as off

    // ----
    // Function decode from the assignment table
    // ----
    assign ext = {q.lvl, 1'b0};

    // One selector per function, polarity fixed where required
    generate
        for (genvar f = 0; f < NF; f++)
        begin : g_fn
            logic [3:0] term;
            logic       inv;
            logic       fixp;
            assign term = q.asg[f][`SSIL_F_TERM];
            assign inv  = q.asg[f][`SSIL_F_INV];
            assign fixp = FIXP[f];
            // Terminal above ten leaves the function off; terminal 0 is off unless inverted
            assign fn[f] = (term <= `SSIL_TERM_MAX) ?
                ext[term] ^ (inv & ~fixp) : 1'b0;
        end
    endgenerate

    // ----
    // Next-state logic
    // ----
    always_comb
    begin
        logic       fot;
        logic       rot;
        logic       aclr;
        logic       ecl;
        logic       ecl_ok;
        logic       ipg_ok;
        logic       clr_done;
        logic       ipg_on;
        logic [3:0] gsw_act;
        logic [4:0] al_set;
        logic [4:0] al_clr;
        logic [3:0] aidx;

        next_q   = q;
        fot      = fn[`SSIL_FN_FOT];
        rot      = fn[`SSIL_FN_ROT];
        aclr     = fn[`SSIL_FN_ACLR];
        ecl      = fn[`SSIL_FN_ECL];
        clr_done = 1'b0;
        gsw_act  = q.gsw[`SSIL_F_GPOS];
        al_set   = '0;
        al_clr   = '0;
        aidx     = reg_addr[5:2];

        // Three-stage synchroniser; a change is taken once
        // stages two and three agree
        next_q.s1 = seq_terminal;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        for (int i = 0; i < 10; i++)
        begin
            if (q.s2[i] == q.s3[i])
            begin
                next_q.lvl[i] = q.s3[i];
            end
        end

        // Fixed terminals: clear on seven, inhibit on ten
        ecl_ok = (q.asg[`SSIL_FN_ECL][`SSIL_F_TERM] ==
                  `SSIL_TERM_ECL);
        ipg_ok = (q.asg[`SSIL_FN_IPG][`SSIL_F_TERM] ==
                  `SSIL_TERM_IPG);
        al_set[`SSIL_AL_ECLASG] = !ecl_ok &&
            q.asg[`SSIL_FN_ECL][`SSIL_F_TERM] != 4'h0;
        al_set[`SSIL_AL_IPGASG] = !ipg_ok &&
            q.asg[`SSIL_FN_IPG][`SSIL_F_TERM] != 4'h0;
        ecl = ecl & ecl_ok;
        ipg_on = fn[`SSIL_FN_IPG] & ipg_ok & !q.ipg_dis;

        // Overtravel handling by enable setting
        next_q.drv.ot_stop_fwd = 1'b0;
        next_q.drv.ot_stop_rev = 1'b0;
        next_q.drv.ot_stop_sel = q.ot_stop;
        if (q.ot_en == `SSIL_OT_STOP)
        begin
            next_q.drv.ot_stop_fwd = fot;
            next_q.drv.ot_stop_rev = rot;
        end
        else if (q.ot_en == `SSIL_OT_ALARM)
        begin
            al_set[`SSIL_AL_OT] = fot | rot;
        end
        al_set[`SSIL_AL_EXTRES]  = ext_alarm_res;
        al_set[`SSIL_AL_EXTKEEP] = ext_alarm_keep;

        // Alarm-clear sequencer: edge starts, long hold releases
        next_q.aclr_prv = aclr;
        case (q.clr)
            ssil_pkg::SSIL_CLR_IDLE:
            begin
                if (aclr && !q.aclr_prv)
                begin
                    next_q.clr     = ssil_pkg::SSIL_CLR_HOLD;
                    next_q.clr_cnt = CW'(1);
                end
            end
            ssil_pkg::SSIL_CLR_HOLD:
            begin
                if (!aclr)
                begin
                    next_q.clr = ssil_pkg::SSIL_CLR_IDLE;
                end
                else if (q.clr_cnt >= CW'(CLR_HOLD_CYC))
                begin
                    clr_done   = 1'b1;
                    next_q.clr = ssil_pkg::SSIL_CLR_REL;
                end
                else
                begin
                    next_q.clr_cnt = q.clr_cnt + CW'(1);
                end
            end
            ssil_pkg::SSIL_CLR_REL:
            begin
                // Wait for release before a new clear
                if (!aclr)
                begin
                    next_q.clr = ssil_pkg::SSIL_CLR_IDLE;
                end
            end
            default:
            begin
                next_q.clr = ssil_pkg::SSIL_CLR_IDLE;
            end
        endcase

        // Only resettable classes drop; a new event wins
        if (clr_done)
        begin
            al_clr = ~`SSIL_ALM_KEEP;
        end
        next_q.drv.alarm = (q.drv.alarm & ~al_clr) | al_set;

        // Error counter zeroing: level, edge or alarm clear
        next_q.ecl_prv = ecl;
        next_q.drv.errcnt_zero = clr_done;
        if (q.ecl_edge)
        begin
            if (ecl && !q.ecl_prv)
            begin
                next_q.drv.errcnt_zero = 1'b1;
            end
        end
        else if (ecl)
        begin
            next_q.drv.errcnt_zero = 1'b1;
        end

        // Main power only with servo-on and no alarm
        next_q.drv.main_power_en = fn[`SSIL_FN_SON] &&
            (next_q.drv.alarm == 5'h00);

        // Loop selection, fixed modes otherwise
        case (q.lmode)
            `SSIL_LM_SPD:
                next_q.drv.active_loop = ssil_pkg::SSIL_LOOP_SPD;
            `SSIL_LM_TRQ:
                next_q.drv.active_loop = ssil_pkg::SSIL_LOOP_TRQ;
            `SSIL_LM_PS:
                next_q.drv.active_loop = fn[`SSIL_FN_MSW] ?
                    ssil_pkg::SSIL_LOOP_SPD :
                    ssil_pkg::SSIL_LOOP_POS;
            `SSIL_LM_PT:
                next_q.drv.active_loop = fn[`SSIL_FN_MSW] ?
                    ssil_pkg::SSIL_LOOP_TRQ :
                    ssil_pkg::SSIL_LOOP_POS;
            `SSIL_LM_ST:
                next_q.drv.active_loop = fn[`SSIL_FN_MSW] ?
                    ssil_pkg::SSIL_LOOP_TRQ :
                    ssil_pkg::SSIL_LOOP_SPD;
            default:
                next_q.drv.active_loop = ssil_pkg::SSIL_LOOP_POS;
        endcase

        // Gain set follows the active loop's switch mode
        case (q.drv.active_loop)
            ssil_pkg::SSIL_LOOP_SPD:
                gsw_act = q.gsw[`SSIL_F_GSPD];
            ssil_pkg::SSIL_LOOP_TRQ:
                gsw_act = q.gsw[`SSIL_F_GTRQ];
            default:
                gsw_act = q.gsw[`SSIL_F_GPOS];
        endcase
        next_q.drv.gain_set2 = (gsw_act == `SSIL_GSW_PIN) &&
                               fn[`SSIL_FN_GAIN_SELECT_IN];

        // Damping filter selection
        if (q.dfilt == `SSIL_DF_PAIR)
        begin
            next_q.drv.filter_en = fn[`SSIL_FN_DFA] ?
                4'hA : 4'h5;
        end
        else if (q.dfilt == `SSIL_DF_ONE)
        begin
            next_q.drv.filter_en = 4'h1 <<
                {fn[`SSIL_FN_DFB], fn[`SSIL_FN_DFA]};
        end
        else
        begin
            next_q.drv.filter_en = 4'h0;
        end

        // Gear numerator by binary code, shared denominator
        next_q.gear = q.gnum[{fn[`SSIL_FN_GEB],
                              fn[`SSIL_FN_GEA]}];

        // Command pulse gate and count
        next_q.pulse = cmd_pulse_in & !ipg_on;
        if (cmd_pulse_in && !ipg_on)
        begin
            next_q.pcnt = q.pcnt + 32'h1;
        end

        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                `SSIL_A_CTRL:
                begin
                    next_q.ot_en    = reg_wdata[`SSIL_F_OTEN];
                    next_q.ot_stop  = reg_wdata[`SSIL_F_OTSTOP];
                    next_q.ecl_edge = reg_wdata[`SSIL_F_ECLEDGE];
                    next_q.lmode    = reg_wdata[`SSIL_F_LMODE];
                    next_q.ipg_dis  = reg_wdata[`SSIL_F_IPGDIS];
                end
                `SSIL_A_GAIN:
                begin
                    next_q.gsw   = reg_wdata[11:0];
                    next_q.dfilt = reg_wdata[`SSIL_F_DFILT];
                end
                `SSIL_A_GNUM1: next_q.gnum[0] = reg_wdata[GW-1:0];
                `SSIL_A_GNUM2: next_q.gnum[1] = reg_wdata[GW-1:0];
                `SSIL_A_GNUM3: next_q.gnum[2] = reg_wdata[GW-1:0];
                `SSIL_A_GNUM4: next_q.gnum[3] = reg_wdata[GW-1:0];
                `SSIL_A_GDEN:  next_q.gden    = reg_wdata[GW-1:0];
                default:
                begin
                    if (reg_addr[7:6] == `SSIL_A_ASG_HI &&
                        aidx < 4'(NF))
                    begin
                        next_q.asg[aidx] = reg_wdata[4:0];
                    end
                end
            endcase
        end

        // Register reads, answered in the following cycle
        next_q.rdata = 32'h0;
        if (reg_rd)
        begin
            case (reg_addr)
                `SSIL_A_CTRL:
                    next_q.rdata = {22'h0, q.ipg_dis, q.lmode,
                        q.ecl_edge, q.ot_stop, q.ot_en};
                `SSIL_A_GAIN:
                    next_q.rdata = {18'h0, q.dfilt, q.gsw};
                `SSIL_A_GNUM1: next_q.rdata = 32'(q.gnum[0]);
                `SSIL_A_GNUM2: next_q.rdata = 32'(q.gnum[1]);
                `SSIL_A_GNUM3: next_q.rdata = 32'(q.gnum[2]);
                `SSIL_A_GNUM4: next_q.rdata = 32'(q.gnum[3]);
                `SSIL_A_GDEN:  next_q.rdata = 32'(q.gden);
                `SSIL_A_STAT:
                    next_q.rdata = {3'h0, q.drv.alarm,
                        2'h0, fn, q.lvl};
                `SSIL_A_PCNT:  next_q.rdata = q.pcnt;
                default:
                begin
                    if (reg_addr[7:6] == `SSIL_A_ASG_HI &&
                        aidx < 4'(NF))
                    begin
                        next_q.rdata = {27'h0, q.asg[aidx]};
                    end
                end
            endcase
        end
    end

    // ----
    // State register with synchronous reset
    // ----
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            q          <= '0;
            q.ot_en    <= 2'h0;
            q.ipg_dis  <= 1'b1;
            q.clr      <= ssil_pkg::SSIL_CLR_IDLE;
            q.asg[`SSIL_FN_ECL] <= {1'b0, `SSIL_TERM_ECL};
            q.asg[`SSIL_FN_IPG] <= {1'b0, `SSIL_TERM_IPG};
            for (int g = 0; g < 4; g++)
            begin
                q.gnum[g] <= GW'(`SSIL_RST_GEAR);
            end
            q.gden     <= GW'(`SSIL_RST_GEAR);
            q.gear     <= GW'(`SSIL_RST_GEAR);
        end
        else
        begin
            q <= next_q;
        end
    end

    // ----
    // Outputs straight from the state register
    // ----
    assign reg_rdata     = q.rdata;
    assign drive         = q.drv;
    assign gear_num      = q.gear;
    assign gear_den      = q.gden;
    assign cmd_pulse_out = q.pulse;

endmodule

//--- dv/ssil_checker.sv
// Assertions on the ports of the sequence-input decoder.
// Assumes alarm clear sits on terminal 3 and inhibit on terminal 10.
`timescale 1ns/100ps
`include "ssil_regs.svh"
module ssil_checker
#(
    parameter int GW           = 16,
    parameter int CLR_HOLD_CYC = 20
)
(
    // Clock, reset and register port
    input wire logic                  ref_clk,
    input wire logic                  rst_b,
    input wire logic [7:0]            reg_addr,
    input wire logic                  reg_wr,
    // Pins and events
    input wire logic [9:0]            seq_terminal,
    input wire logic                  cmd_pulse_in,
    input wire logic                  ext_alarm_res,
    input wire logic                  ext_alarm_keep,
    // Outputs watched
    input wire ssil_pkg::ssil_drive_s drive,
    input wire logic [GW-1:0]         gear_num,
    input wire logic [GW-1:0]         gear_den,
    input wire logic                  cmd_pulse_out
);
    logic [7:0] hi_cnt;  // Cycles the clear terminal has stood high

    // Saturating count of the clear terminal's high time
    always_ff @(posedge ref_clk)
        if (!rst_b || !seq_terminal[2])
            hi_cnt <= 8'h00;
        else if (hi_cnt != 8'hFF)
            hi_cnt <= hi_cnt + 8'h01;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_rst_quiet: assert property ($rose(rst_b) |->
        drive == '0 && gear_num == 1) else $error("busy after reset");
    a_pulse_pass: assert property (
        cmd_pulse_out |-> $past(cmd_pulse_in)) else $error("stray pulse");
    a_pulse_free: assert property (
        (!seq_terminal[9])[*6] ##0 cmd_pulse_in |=> cmd_pulse_out)
        else $error("pulse lost");
    a_power_alarm: assert property (drive.main_power_en |->
        drive.alarm == 0 || $past(drive.alarm) == 0)
        else $error("power with alarm");
    a_keep_sticky: assert property (
        $past(drive.alarm[4]) |-> drive.alarm[4]) else $error("alarm lost");
    a_keep_event: assert property (
        ext_alarm_keep |=> drive.alarm[4]) else $error("keep not set");
    a_res_event: assert property (
        ext_alarm_res |=> drive.alarm[3]) else $error("alarm not set");
    a_clear_hold: assert property (
        $fell(drive.alarm[3]) |-> hi_cnt >= CLR_HOLD_CYC)
        else $error("clear too early");
    a_clear_zero: assert property ($fell(drive.alarm[3]) |->
        $past(drive.errcnt_zero) or ##[0:1] drive.errcnt_zero)
        else $error("no counter zero");
    a_den_write: assert property ($changed(gear_den) |->
        $past(reg_wr) && $past(reg_addr) == `SSIL_A_GDEN)
        else $error("denominator moved");

    c_clear: cover property ($fell(drive.alarm[3]));
    c_ecl: cover property ($rose(drive.errcnt_zero));
    c_pulse: cover property (cmd_pulse_in ##1 cmd_pulse_out);
endmodule

bind ssil_seq_input ssil_checker #(.GW(GW), .CLR_HOLD_CYC(CLR_HOLD_CYC))
    ssil_checker_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .seq_terminal(seq_terminal),
    .cmd_pulse_in(cmd_pulse_in), .ext_alarm_res(ext_alarm_res),
    .ext_alarm_keep(ext_alarm_keep), .drive(drive), .gear_num(gear_num),
    .gear_den(gear_den), .cmd_pulse_out(cmd_pulse_out));

//--- dv/ssil_host_model.sv
// Host controller model driving the ten input terminals.
// Assumes servo-on on terminal 4, clear on 3, counter clear on 7.
`timescale 1ns/100ps
module ssil_host_model
#(
    parameter int ECL_MIN = 8
)
(
    // Clock
    input  wire logic       ref_clk,
    // Levels asked for by the bench
    input  wire logic [9:0] want,
    // Terminals into the drive
    output      logic [9:0] seq_terminal
);
    int ecl_cnt = 0;  // Cycles the counter clear has been held

    initial seq_terminal = 10'h000;

    // Pins follow the requests one edge late, like a controller scan
    always @(posedge ref_clk)
    begin
        seq_terminal <= want;
        if (want[2])
            seq_terminal[3] <= 1'b0;
        if (want[6] || (ecl_cnt != 0 && ecl_cnt < ECL_MIN))
        begin
            seq_terminal[6] <= 1'b1;
            ecl_cnt <= ecl_cnt + 1;
        end
        else
            ecl_cnt <= 0;
    end
endmodule

//--- dv/tb_ssil_seq_input.sv
// Self-checking bench for the sequence-input decoder.
// Assumes the host model and the bound checker beside the design.
`timescale 1ns/100ps
module tb_ssil_seq_input;
    logic rst_b = 0, reg_wr = 0, reg_rd = 0, cmd_pulse_in = 0, ref_clk;
    logic ext_alarm_res = 0, ext_alarm_keep = 0, cmd_pulse_out;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [9:0] want = 10'h000, seq_terminal;
    logic [15:0] gear_num, gear_den;
    ssil_pkg::ssil_drive_s drive;
    int n_fail = 0, checks_done = 0, i, n;
    // Decode rows: control, gain, pins, {loop,gain2,0,filters}, numerator
    logic [15:0] r_ctrl [7] = '{16'h260, 16'h260, 16'h280, 16'h2A0,
                                16'h2A0, 16'h2A0, 16'h220};
    logic [15:0] r_gain [7] = '{16'h1222, 16'h1222, 16'h2222, 16'h2222,
                                16'h2222, 16'h2000, 16'h2222};
    logic [9:0] r_term [7] = '{10'h000, 10'h138, 10'h00B, 10'h123,
                               10'h038, 10'h019, 10'h008};
    logic [7:0] r_exp [7] = '{8'h05, 8'h6A, 8'h84, 8'h48, 8'hA2, 8'h84, 8'h41};
    logic [7:0] r_gnum[7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h11, 8'h11, 8'h11};
    logic [3:0] r_asg [6] = '{4'h4, 4'h5, 4'h6, 4'h1, 4'h9, 4'h2};

    ssil_seq_input #(.CLR_HOLD_CYC(20)) ssil_seq_input_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .seq_terminal(seq_terminal),
        .cmd_pulse_in(cmd_pulse_in), .ext_alarm_res(ext_alarm_res),
        .ext_alarm_keep(ext_alarm_keep), .drive(drive),
        .gear_num(gear_num), .gear_den(gear_den),
        .cmd_pulse_out(cmd_pulse_out));
    ssil_host_model ssil_host_model_inst (.ref_clk(ref_clk), .want(want),
        .seq_terminal(seq_terminal));

    // 40 MHz clock
    initial
    begin
        ref_clk = 0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Pin change, then wait out the synchroniser
    task automatic pins(input logic [9:0] v);
        @(posedge ref_clk);
        want <= v;
        repeat (7) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(input logic exp);
        @(posedge ref_clk);
        cmd_pulse_in <= 1'b1;
        @(posedge ref_clk);
        cmd_pulse_in <= 1'b0;
        #1 chk(cmd_pulse_out, exp);
    endtask
    task automatic do_reset;
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        do_reset;
        chk(drive, 0);
        chk({gear_num, gear_den}, 32'h00010001);
        rd(8'h00, 32'h200);
        rd(8'h4C, 32'h7);
        rd(8'h68, 32'hA);
        rd(8'h3C, 32'h0);
        for (i = 0; i < 4; i++)
            wr(8'h08 + 8'(4 * i), 32'h11 * 32'(i + 1));
        wr(8'h18, 32'h55);
        for (i = 0; i < 6; i++)
            wr(8'h50 + 8'(4 * i), 32'(r_asg[i]));
        for (i = 0; i < 7; i++)
        begin
            wr(8'h00, 32'(r_ctrl[i]));
            wr(8'h04, 32'(r_gain[i]));
            pins(r_term[i]);
            chk({drive.active_loop, drive.gain_set2, 1'b0, drive.filter_en},
                32'(r_exp[i]));
            chk(gear_num, 32'(r_gnum[i]));
        end
        chk(gear_den, 32'h55);
        $display("decode table done");
        wr(8'h00, 32'h200);
        pins(10'h040);
        chk(drive.errcnt_zero, 1);
        wr(8'h4C, 32'h17);
        pins(10'h000);
        chk(drive.errcnt_zero, 0);
        wr(8'h4C, 32'h7);
        wr(8'h00, 32'h210);
        want <= 10'h040;
        n = 0;
        repeat (16)
        begin
            @(posedge ref_clk);
            #1 n += drive.errcnt_zero;
        end
        chk(n, 1);
        pins(10'h000);
        $display("counter clear done");
        wr(8'h00, 32'h000);
        pins(10'h200);
        pulse(0);
        rd(8'h20, 32'h0);
        pins(10'h000);
        pulse(1);
        wr(8'h00, 32'h200);
        pins(10'h200);
        pulse(1);
        rd(8'h20, 32'h2);
        $display("pulse inhibit done");
        wr(8'h40, 32'h1);
        wr(8'h44, 32'h2);
        wr(8'h48, 32'h3);
        wr(8'h50, 32'h0);
        wr(8'h6C, 32'h4);
        wr(8'h00, 32'h208);
        pins(10'h00B);
        chk({drive.main_power_en, drive.ot_stop_fwd, drive.ot_stop_rev,
            drive.ot_stop_sel}, 5'h12);
        wr(8'h00, 32'h209);
        pins(10'h00B);
        chk({drive.main_power_en, drive.ot_stop_fwd, drive.ot_stop_rev,
            drive.ot_stop_sel}, 5'h1E);
        wr(8'h00, 32'h202);
        pins(10'h009);
        chk({drive.main_power_en, drive.alarm}, 6'h01);
        @(posedge ref_clk);
        {ext_alarm_keep, ext_alarm_res} <= 2'h3;
        @(posedge ref_clk);
        {ext_alarm_keep, ext_alarm_res} <= 2'h0;
        pins(10'h00C);
        pins(10'h000);
        chk(drive.alarm, 5'h19);
        @(posedge ref_clk);
        want <= 10'h00C;
        for (i = 0; i < 60 && drive.alarm !== 5'h10; i++)
            @(posedge ref_clk);
        #1 chk(drive.alarm, 5'h10);
        pins(10'h008);
        chk(drive.main_power_en, 0);
        $display("alarm clear done");
        wr(8'h4C, 32'h5);
        wr(8'h68, 32'h3);
        pins(10'h000);
        chk(drive.alarm, 5'h16);
        do_reset;
        chk(drive.alarm, 0);
        $display("allocation done");
        end_of_test;
    end
endmodule
